// ===== src/ipp_pkg.sv
// Purpose: Shared constants and types for the init status and power profile register bank.
// Assumes: Register access is a simple synchronous read/write port with a 12-bit address and 8-bit data.
// Notes:   The offsets are byte addresses of the control port.
package ipp_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [11:0] OFS_INIT_PROGRESS_STATUS = 12'h270;
  localparam logic [11:0] OFS_POWER_PROFILE_B      = 12'h29A;
  localparam logic [11:0] OFS_POWER_PROFILE_C      = 12'h29B;
  localparam logic [11:0] OFS_POWER_PROFILE_D      = 12'h29C;

  // Field position of the initialization-complete flag.
  localparam int unsigned INIT_DONE_BIT = 0;

  // Profile codes.
  localparam logic [7:0] CODE_B_LOW  = 8'h06;
  localparam logic [7:0] CODE_B_HIGH = 8'h0F;
  localparam logic [7:0] CODE_C_LOW  = 8'h00;
  localparam logic [7:0] CODE_C_HIGH = 8'h04;
  localparam logic [7:0] CODE_D_LOW  = 8'h14;
  localparam logic [7:0] CODE_D_HIGH = 8'h1B;

  // Reset values.
  localparam logic [7:0] RST_INIT_PROGRESS_STATUS = 8'h00;
  localparam logic [7:0] RST_POWER_PROFILE_B      = CODE_B_HIGH;
  localparam logic [7:0] RST_POWER_PROFILE_C      = CODE_C_HIGH;
  localparam logic [7:0] RST_POWER_PROFILE_D      = CODE_D_HIGH;

  // Length of the internal initialization sequence in core clock cycles.
  localparam int unsigned INIT_CYCLES = 64;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } ipp_req_t;

  typedef struct packed {
    logic [7:0] profile_code_b;
    logic [7:0] profile_code_c;
    logic [7:0] profile_code_d;
  } ipp_profile_t;

  typedef enum logic [1:0] {
    IPP_RESET = 2'b00,
    IPP_INIT  = 2'b01,
    IPP_DONE  = 2'b11
  } ipp_state_t;

endpackage : ipp_pkg

// ===== src/ipp_regs.sv
// Purpose: Initialization status flag and power profile registers of the converter control port.
// Assumes: Requests are synchronous to core_clk; one request per cycle, read data valid one cycle later.
// Notes:   Software reset restarts the initialization sequence exactly like power-on reset.
//          Every output is flopped, so each one lags the request or state change behind it by one edge.
//          Reserved profile codes are not filtered; a bad code simply reads back as written.
//          The low-power indication is only a summary for the converter; the registers stay the reference.
// Operation
// - Status bit 0 reads 1 after initialization completes, 0 before.
// - Profile register b: low power 0x06, high performance 0x0F, reset 0x0F.
// - Profile register c: low power 0x00, high performance 0x04, reset 0x04.
// - Profile register d: low power 0x14, high performance 0x1B, reset 0x1B.
module ipp_regs #(
  parameter int unsigned INIT_LEN = ipp_pkg::INIT_CYCLES
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire logic                 soft_reset,
  // Register access
  input  wire ipp_pkg::ipp_req_t    req,
  output logic [7:0]                rdata,
  output logic                      rvalid,
  // Status and configuration to the converter
  output logic                      init_done,
  output ipp_pkg::ipp_profile_t     profile,
  output logic                      low_power_sel
);
  import ipp_pkg::*;

  localparam int unsigned CNT_W = $clog2(INIT_LEN + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INIT_LEN - 1);

  // Sequencer state.
  ipp_state_t       state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             init_done_q;

  // Register contents.
  logic [7:0]       code_b_q;
  logic [7:0]       code_c_q;
  logic [7:0]       code_d_q;
  ipp_profile_t     profile_cur;
  logic             low_q;

  // Read port.
  logic [7:0]       rdata_q;
  logic             rvalid_q;

  // Decoded write strobes.
  logic             wr_b;
  logic             wr_c;
  logic             wr_d;

  // Offset match, shared by the write strobes and the read multiplexer.
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Read value of one offset; unmapped offsets and the reserved status bits read zero.
  function automatic logic [7:0] read_value(input logic [11:0] a, input logic flag, input ipp_profile_t p);
    if (hit(a, OFS_INIT_PROGRESS_STATUS)) begin
      read_value = {7'h00, flag};
    end else if (hit(a, OFS_POWER_PROFILE_B)) begin
      read_value = p.profile_code_b;
    end else if (hit(a, OFS_POWER_PROFILE_C)) begin
      read_value = p.profile_code_c;
    end else if (hit(a, OFS_POWER_PROFILE_D)) begin
      read_value = p.profile_code_d;
    end else begin
      read_value = 8'h00;
    end
  endfunction : read_value

  // True when every profile register holds its low-power code.
  function automatic logic all_low(input ipp_profile_t p);
    all_low = (p.profile_code_b == CODE_B_LOW)
              && (p.profile_code_c == CODE_C_LOW)
              && (p.profile_code_d == CODE_D_LOW);
  endfunction : all_low

  // Write strobes. A software reset in the same cycle wins over the write.
  always_comb begin
    wr_b = 1'b0;
    wr_c = 1'b0;
    wr_d = 1'b0;
    if (req.wr_en && !soft_reset) begin
      wr_b = hit(req.addr, OFS_POWER_PROFILE_B);
      wr_c = hit(req.addr, OFS_POWER_PROFILE_C);
      wr_d = hit(req.addr, OFS_POWER_PROFILE_D);
    end
  end

  // Initialization sequencer; a software reset restarts it from the beginning.
  // One edge leaves the reset state, INIT_LEN edges count, and the flag follows one edge later,
  // so the flag rises INIT_LEN + 2 edges after either reset ends.
  // The length is a parameter because the real sequence time is not fixed here;
  // simulation uses a short one. Any stray state code falls back to a fresh start
  // rather than leaving the flag stuck.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= IPP_RESET;
      cnt_q   <= '0;
    end else if (soft_reset) begin
      state_q <= IPP_RESET;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        IPP_RESET: begin
          state_q <= IPP_INIT;
          cnt_q   <= '0;
        end
        IPP_INIT: begin
          if (cnt_q == CNT_LAST) begin
            state_q <= IPP_DONE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        IPP_DONE: begin
          state_q <= IPP_DONE;
        end
        default: begin
          state_q <= IPP_RESET;
        end
      endcase
    end
  end

  // The flag is a pure function of the sequencer; writes to its offset are dropped.
  // A software reset clears it at the very edge that samples the reset, so a host
  // polling the flag with a status read issued after that edge never reads a stale 1 while the sequence restarts.
  // Nothing but the two resets and the sequencer can move it.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_done_q <= RST_INIT_PROGRESS_STATUS[INIT_DONE_BIT];
    end else begin
      init_done_q <= (state_q == IPP_DONE) && !soft_reset;
    end
  end

  // Profile register b. Reserved codes are stored as written; checking them is the host's job.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      code_b_q <= RST_POWER_PROFILE_B;
    end else if (soft_reset) begin
      code_b_q <= RST_POWER_PROFILE_B;
    end else if (wr_b) begin
      code_b_q <= req.wdata;
    end
  end

  // Profile register c.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      code_c_q <= RST_POWER_PROFILE_C;
    end else if (soft_reset) begin
      code_c_q <= RST_POWER_PROFILE_C;
    end else if (wr_c) begin
      code_c_q <= req.wdata;
    end
  end

  // Profile register d.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      code_d_q <= RST_POWER_PROFILE_D;
    end else if (soft_reset) begin
      code_d_q <= RST_POWER_PROFILE_D;
    end else if (wr_d) begin
      code_d_q <= req.wdata;
    end
  end

  // The three registers seen as one profile word.
  assign profile_cur = {code_b_q, code_c_q, code_d_q};

  // Low power is reported only when all three registers hold their low codes.
  // The extra flop costs a cycle of lag but keeps the output straight from a register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 1'b0;
    end else begin
      low_q <= all_low(profile_cur);
    end
  end

  // Read answer strobe; it comes exactly one cycle after the request.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd_en;
    end
  end

  // Read data holds between reads, so a late sampler still sees the last answer.
  // A read in the same cycle as a write returns the old value.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (req.rd_en) begin
      rdata_q <= read_value(req.addr, init_done_q, profile_cur);
    end
  end

  assign rdata         = rdata_q;
  assign rvalid        = rvalid_q;
  assign init_done     = init_done_q;
  assign profile       = profile_cur;
  assign low_power_sel = low_q;

endmodule : ipp_regs

// ===== verification/ipp_host.sv
// Purpose: Host model issuing register requests.
// Assumes: Calibration and serial link are off.
// Notes:   Released request fields show inverted values.
module ipp_host (
  input  wire logic         core_clk,
  input  wire logic [7:0]   rdata,
  input  wire logic         rvalid,
  output ipp_pkg::ipp_req_t req,
  output logic              soft_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  import ipp_pkg::*;
  initial begin
    req = '0;
    soft_reset = 1'b0;
  end
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge core_clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    req <= '{1'b0, 1'b0, ~a, 8'hFF};
    #1 d = rvalid ? rdata : 8'hXX;
  endtask : rd
  // The rate is assumed low enough, and calibration follows outside this bank.
  task automatic set_low;
    wr(OFS_POWER_PROFILE_B, CODE_B_LOW);
    wr(OFS_POWER_PROFILE_C, CODE_C_LOW);
    wr(OFS_POWER_PROFILE_D, CODE_D_LOW);
  endtask : set_low
  task automatic sreset;
    @(posedge core_clk);
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
  endtask : sreset
endmodule : ipp_host

// ===== verification/ipp_props.sv
// Purpose: Port checker for the register bank.
// Assumes: One request per cycle.
// Notes:   Bound into every ipp_regs instance.
module ipp_props #(
  parameter int unsigned INIT_LEN = ipp_pkg::INIT_CYCLES
) (
  input wire logic                  core_clk,
  input wire logic                  arst_n,
  input wire logic                  soft_reset,
  input wire ipp_pkg::ipp_req_t     req,
  input wire logic [7:0]            rdata,
  input wire logic                  rvalid,
  input wire logic                  init_done,
  input wire ipp_pkg::ipp_profile_t profile,
  input wire logic                  low_power_sel
);
  import ipp_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_stat;
    req.rd_en && req.addr == OFS_INIT_PROGRESS_STATUS |=> rvalid && rdata == {7'h00, $past(init_done)};
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_wrb;
    req.wr_en && req.addr == OFS_POWER_PROFILE_B && !soft_reset |=> profile.profile_code_b == $past(req.wdata);
  endproperty
  a_wrb: assert property (p_wrb) else $error("profile b write lost");
  property p_low;
    profile == {CODE_B_LOW, CODE_C_LOW, CODE_D_LOW} |=> low_power_sel;
  endproperty
  a_low: assert property (p_low) else $error("low power select missing");
  property p_high;
    profile != {CODE_B_LOW, CODE_C_LOW, CODE_D_LOW} |=> !low_power_sel;
  endproperty
  a_high: assert property (p_high) else $error("low power select without all low codes");
  property p_srst;
    soft_reset |=> profile == {CODE_B_HIGH, CODE_C_HIGH, CODE_D_HIGH};
  endproperty
  a_srst: assert property (p_srst) else $error("profile not reset");
  property p_clr;
    soft_reset |=> ##[0:1] !init_done;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_ro;
    req.wr_en && req.addr == OFS_INIT_PROGRESS_STATUS && !soft_reset |=> $stable(profile);
  endproperty
  a_ro: assert property (p_ro) else $error("status write had effect");
endmodule : ipp_props
bind ipp_regs ipp_props #(.INIT_LEN(INIT_LEN)) props_u (.core_clk, .arst_n, .soft_reset, .req, .rdata,
  .rvalid, .init_done, .profile, .low_power_sel);

// ===== verification/ipp_regs_tb_top.sv
// Purpose: Self-checking bench for the register bank.
// Assumes: Short init length for speed.
// Notes:   Power-on init check first, row table next, low-power check, soft reset case last.
module ipp_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ipp_pkg::*;
  localparam int unsigned LEN = 4;
  typedef struct {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e;} ipp_row_t;
  logic         core_clk, arst_n, soft_reset, rvalid, init_done, low_power_sel;
  logic [7:0]   rdata, got;
  ipp_req_t     req;
  ipp_profile_t profile;
  int           fail_count = 0, n_compared = 0, n;
  ipp_row_t rows[11] = '{'{0, OFS_POWER_PROFILE_B, 8'h00, CODE_B_HIGH}, '{0, OFS_POWER_PROFILE_C, 8'h00, CODE_C_HIGH},
    '{0, OFS_POWER_PROFILE_D, 8'h00, CODE_D_HIGH}, '{1, OFS_POWER_PROFILE_B, CODE_B_LOW, CODE_B_LOW},
    '{1, OFS_POWER_PROFILE_C, CODE_C_LOW, CODE_C_LOW}, '{1, OFS_POWER_PROFILE_D, CODE_D_LOW, CODE_D_LOW},
    '{1, OFS_POWER_PROFILE_B, CODE_B_HIGH, CODE_B_HIGH}, '{1, OFS_POWER_PROFILE_C, CODE_C_HIGH, CODE_C_HIGH},
    '{1, OFS_POWER_PROFILE_D, CODE_D_HIGH, CODE_D_HIGH}, '{1, 12'h29D, 8'h55, 8'h00},
    '{1, OFS_INIT_PROGRESS_STATUS, 8'hFE, 8'h01}};
  ipp_regs #(.INIT_LEN(LEN)) dut_u (.core_clk, .arst_n, .soft_reset, .req, .rdata, .rvalid, .init_done,
    .profile, .low_power_sel);
  ipp_host host_u (.core_clk, .rdata, .rvalid, .req, .soft_reset);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wait_init;
    n = 0;
    while (init_done !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(8'(n), 8'(LEN + 2));
  endtask : wait_init
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    arst_n = 1'b0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    #1 chk({7'h00, init_done}, 8'h00);
    wait_init;
    foreach (rows[i]) begin
      if (rows[i].w) host_u.wr(rows[i].a, rows[i].d);
      host_u.rd(rows[i].a, got);
      chk(got, rows[i].e);
    end
    chk({7'h00, low_power_sel}, 8'h00);
    $display("test rows done");
    host_u.set_low;
    @(posedge core_clk);
    #1 chk({7'h00, low_power_sel}, 8'h01);
    host_u.sreset;
    #1 chk(profile.profile_code_d, CODE_D_HIGH);
    chk({7'h00, init_done}, 8'h00);
    wait_init;
    host_u.rd(OFS_POWER_PROFILE_C, got);
    chk(got, CODE_C_HIGH);
    $display("test soft reset done");
    results;
  end
  initial begin
    #50us;
    fail_count++;
    results;
  end
endmodule : ipp_regs_tb_top
